//--- bpcs_regs.sv
`timescale 1ns/1ps
module bpcs_regs
  import bpcs_pkg::*;
#(
  // Revision number; the value is arbitrary.
  parameter logic [7:0] REV_NUMBER = 8'h01,
  // High when this revision carries a capability list.
  parameter logic CAP_LIST = 1'b1
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic nrst,
  // Configuration access from the primary bus target.
  input wire bpcs_cfg_req_t cfg_req,
  output logic [31:0] cfg_rdata_r,
  output logic cfg_ack_r,
  // Primary bus events from the bridge logic.
  input wire bpcs_event_t events,
  // Open-drain system error pin.
  output logic serr_o_r,
  output logic serr_oe_r,
  // Command bits that steer the bridge.
  output bpcs_cmd_t cmd_r,
  // Sticky status flags, for the bridge's own use.
  output logic [NFLAG-1:0] flags_r
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  // All registered state of this module in one word, except the sticky flags, which the flag bank holds.
  typedef struct packed {
    bpcs_cmd_t cmd;
    logic serr_oe;
    logic serr_lvl; // Pin level while driven; it never leaves zero.
    logic ack;
    logic [31:0] rdata;
  } bpcs_state_t;

  bpcs_state_t s_r; // Registered state.
  bpcs_state_t s_nxt; // Next state.
  logic hit_cs; // Access targets the command/status dword.
  logic hit_rev; // Access targets the revision dword.
  logic [NFLAG-1:0] flag_set; // Hardware set events.
  logic [NFLAG-1:0] flag_clr; // Software clear requests.
  logic [NFLAG-1:0] flags; // Current sticky flags.

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // True when a byte address falls in the dword holding an offset.
  function automatic logic dword_hit(input logic [7:0] a,
                                     input logic [7:0] ofs);
    dword_hit = (a[7:2] == ofs[7:2]);
  endfunction

  // Builds the command/status dword as seen by a reader.
  // Unlisted bits stay zero, which covers every reserved field.
  function automatic logic [31:0] cs_word(input bpcs_cmd_t c,
                                          input logic [NFLAG-1:0] f);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[CMD_PERR_RESP_BIT] = c.perr_resp;
    w[CMD_WAIT_BIT] = WAIT_CTRL_VAL;
    w[CMD_SERR_EN_BIT] = c.serr_en;
    w[CMD_FB2B_EN_BIT] = c.fb2b_en;
    w[ST_CAP_LIST_BIT] = CAP_LIST;
    w[ST_66MHZ_BIT] = CAP66_VAL;
    w[ST_FB2B_CAP_BIT] = FB2B_CAP_VAL;
    w[ST_DPD_BIT] = f[F_DPD];
    w[ST_DEVSEL_HI:ST_DEVSEL_LO] = DEVSEL_MEDIUM;
    w[ST_STA_BIT] = f[F_STA];
    w[ST_RTA_BIT] = f[F_RTA];
    w[ST_RMA_BIT] = f[F_RMA];
    w[ST_SSE_BIT] = f[F_SSE];
    w[ST_DPE_BIT] = f[F_DPE];
    cs_word = w;
  endfunction

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  // Decoding is on the dword only; byte enables pick the lanes.
  always_comb begin
    hit_cs = dword_hit(cfg_req.addr, OFS_COMMAND);
    hit_rev = dword_hit(cfg_req.addr, OFS_REVISION);
  end

  // ---------------------------------------------------------------
  // Sticky flag events
  // ---------------------------------------------------------------
  // Events come from logic on the same clock, so no synchroniser.
  always_comb begin
    flag_set = '0;
    flag_set[F_DPD] = events.master_active & events.parity_seen &
                      s_r.cmd.perr_resp;
    flag_set[F_STA] = events.tgt_abort_sig;
    flag_set[F_RTA] = events.tgt_abort_rcv;
    flag_set[F_RMA] = events.mst_abort_rcv;
    flag_set[F_SSE] = s_r.serr_oe;
    flag_set[F_DPE] = events.addr_perr | events.data_perr;
  end

  // Software clears; all six flags sit in the top byte lane.
  always_comb begin
    flag_clr = '0;
    if (cfg_req.wr && hit_cs && !cfg_req.be_n[LANE_ST_HI]) begin
      flag_clr[F_DPD] = cfg_req.wdata[ST_DPD_BIT];
      flag_clr[F_STA] = cfg_req.wdata[ST_STA_BIT];
      flag_clr[F_RTA] = cfg_req.wdata[ST_RTA_BIT];
      flag_clr[F_RMA] = cfg_req.wdata[ST_RMA_BIT];
      flag_clr[F_SSE] = cfg_req.wdata[ST_SSE_BIT];
      flag_clr[F_DPE] = cfg_req.wdata[ST_DPE_BIT];
    end
  end

  // The flag bank resolves set against clear.
  bpcs_w1c_bank #(
    .N(NFLAG)
  ) u_flags (
    .clock(clock),
    .nrst(nrst),
    .set(flag_set),
    .clr(flag_clr),
    .flags_r(flags)
  );

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    // Every access is answered one cycle later.
    s_nxt.ack = cfg_req.rd | cfg_req.wr;
    // Command writes, lane by lane.
    if (cfg_req.wr && hit_cs) begin
      if (!cfg_req.be_n[LANE_CMD_LO]) begin
        s_nxt.cmd.perr_resp = cfg_req.wdata[CMD_PERR_RESP_BIT];
        // Bit 7 is not stored, so writes to it are lost.
      end
      if (!cfg_req.be_n[LANE_CMD_HI]) begin
        s_nxt.cmd.serr_en = cfg_req.wdata[CMD_SERR_EN_BIT];
        s_nxt.cmd.fb2b_en = cfg_req.wdata[CMD_FB2B_EN_BIT];
      end
    end
    s_nxt.serr_oe = events.serr_req & s_r.cmd.serr_en;
    // The pin only ever pulls low, so its level flop stays at zero.
    s_nxt.serr_lvl = 1'b0;
    // Read data is captured at the request and held until the next.
    if (cfg_req.rd) begin
      if (hit_cs) begin
        s_nxt.rdata = cs_word(s_r.cmd, flags);
      end else if (hit_rev) begin
        // revision number read
        // Class code bytes above are served elsewhere and read zero.
        s_nxt.rdata = {24'h00_0000, REV_NUMBER};
      end else begin
        // Dwords outside this block read zero.
        s_nxt.rdata = 32'h0000_0000;
      end
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!nrst) begin
      s_r.cmd.fb2b_en <= CMD_RESET;
      s_r.cmd.serr_en <= CMD_RESET;
      s_r.cmd.perr_resp <= CMD_RESET;
      s_r.serr_oe <= 1'b0;
      s_r.serr_lvl <= 1'b0;
      s_r.ack <= 1'b0;
      s_r.rdata <= 32'h0000_0000;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // The pin level is low whenever driven; the enable does the work.
  // Keeping the level at zero avoids a glitch to high on release.
  always_comb begin
    cfg_rdata_r = s_r.rdata;
    cfg_ack_r = s_r.ack;
    serr_oe_r = s_r.serr_oe;
    serr_o_r = s_r.serr_lvl;
    cmd_r = s_r.cmd;
    flags_r = flags;
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);

  // Helper taps so that $past sees plain signals.
  logic wd_fb2b; // Written fast back-to-back enable.
  logic wd_serr; // Written error enable.
  logic [7:0] wd_top; // Written top status byte.
  logic wd_perr; // Written parity response enable.
  assign wd_fb2b = cfg_req.wdata[CMD_FB2B_EN_BIT];
  assign wd_serr = cfg_req.wdata[CMD_SERR_EN_BIT];
  assign wd_top = cfg_req.wdata[31:24];
  assign wd_perr = cfg_req.wdata[CMD_PERR_RESP_BIT];

  // A read of the command/status dword.
  sequence s_rd_cs;
    cfg_req.rd && hit_cs;
  endsequence

  // A write to the upper command byte.
  sequence s_wr_cmd_hi;
    cfg_req.wr && hit_cs && !cfg_req.be_n[LANE_CMD_HI];
  endsequence

  // A clear of the detected parity flag with no new parity event.
  sequence s_clr_dpe_quiet;
    flag_clr[F_DPE] && !events.addr_perr && !events.data_perr;
  endsequence

  // Error request arriving while the enable is set.
  sequence s_serr_fire;
    events.serr_req && cmd_r.serr_en;
  endsequence

  a_wait_reserved_zero: assert property (
    s_rd_cs |=> !cfg_rdata_r[CMD_WAIT_BIT] && cfg_rdata_r[15:10] == 6'h00)
    else $error("wait bit or reserved command bits not zero");

  a_status_reserved: assert property (
    s_rd_cs |=> cfg_rdata_r[19:16] == 4'h0 && !cfg_rdata_r[22])
    else $error("reserved status bits not zero");

  a_serr_gated: assert property (
    !cmd_r.serr_en |=> !serr_oe_r)
    else $error("error pin driven while disabled");

  a_serr_to_flag: assert property (
    s_serr_fire ##1 serr_oe_r |=> flags[F_SSE])
    else $error("system error flag not set after pin drive");

  a_fb2b_write: assert property (
    s_wr_cmd_hi |=> cmd_r.fb2b_en == $past(wd_fb2b) &&
                    cmd_r.serr_en == $past(wd_serr))
    else $error("upper command byte not stored");

  a_fixed_caps: assert property (
    s_rd_cs |=> cfg_rdata_r[ST_FB2B_CAP_BIT] && !cfg_rdata_r[ST_66MHZ_BIT] &&
                cfg_rdata_r[ST_DEVSEL_HI:ST_DEVSEL_LO] == DEVSEL_MEDIUM &&
                cfg_rdata_r[ST_CAP_LIST_BIT] == CAP_LIST)
    else $error("fixed capability fields wrong");

  a_dpd_cause: assert property (
    $rose(flags[F_DPD]) |->
      $past(s_r.cmd.perr_resp) && $past(events.master_active) &&
      $past(events.parity_seen))
    else $error("parity detected flag set without cause");

  a_dpe_sets: assert property (
    (events.addr_perr || events.data_perr) |=> flags[F_DPE] [*1])
    else $error("detected parity flag not set");

  a_w1c_clears: assert property (
    s_clr_dpe_quiet |=> !flags[F_DPE])
    else $error("write one did not clear the flag");

  a_set_wins: assert property (
    (flag_set[F_STA] && flag_clr[F_STA]) |=> flags[F_STA])
    else $error("clear beat a same-cycle set");

  a_rev_read: assert property (
    (cfg_req.rd && hit_rev) |=> cfg_ack_r &&
                                cfg_rdata_r == {24'h00_0000, REV_NUMBER})
    else $error("revision dword read wrong");

  a_abort_flags: assert property (
    (events.tgt_abort_rcv && events.mst_abort_rcv) |=>
      flags[F_RTA] && flags[F_RMA])
    else $error("abort flags not set");

  a_top_write_wins: assert property (
    (cfg_req.wr && hit_cs && !cfg_req.be_n[LANE_ST_HI] &&
     events.mst_abort_rcv) |=> flags[F_RMA])
    else $error("master abort lost against clear");

  // A quiet top-lane write clears on one and keeps the flag on zero.
  a_sta_w1c: assert property (
    (cfg_req.wr && hit_cs && !cfg_req.be_n[LANE_ST_HI] && !events.tgt_abort_sig) |=>
      flags[F_STA] ==
      ($past(flags[F_STA]) && !$past(wd_top[ST_STA_BIT - 8 * LANE_ST_HI])))
    else $error("signalled target abort flag wrong after write");

  a_sta_sets: assert property (
    events.tgt_abort_sig |=> flags[F_STA])
    else $error("signalled target abort flag not set");

  a_dpd_sets: assert property (
    (events.master_active && events.parity_seen && cmd_r.perr_resp) |=>
      flags[F_DPD])
    else $error("parity detected flag not set");

  a_perr_write: assert property (
    (cfg_req.wr && hit_cs && !cfg_req.be_n[LANE_CMD_LO]) |=>
      cmd_r.perr_resp == $past(wd_perr))
    else $error("parity response enable not stored");

  a_serr_follows: assert property (
    s_serr_fire |=> serr_oe_r)
    else $error("error pin not driven while enabled");

endmodule

//--- bpcs_pkg.sv
package bpcs_pkg;

  // ---------------------------------------------------------------
  // Configuration offsets (byte addresses on the primary bus)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_COMMAND = 8'h04;
  localparam logic [7:0] OFS_PRIMARY_STATUS = 8'h06;
  localparam logic [7:0] OFS_REVISION = 8'h08;

  // ---------------------------------------------------------------
  // Field positions inside the combined dwords
  // ---------------------------------------------------------------
  localparam int CMD_PERR_RESP_BIT = 6;
  localparam int CMD_WAIT_BIT = 7;
  localparam int CMD_SERR_EN_BIT = 8;
  localparam int CMD_FB2B_EN_BIT = 9;
  localparam int ST_CAP_LIST_BIT = 20;
  localparam int ST_66MHZ_BIT = 21;
  localparam int ST_FB2B_CAP_BIT = 23;
  localparam int ST_DPD_BIT = 24;
  localparam int ST_DEVSEL_LO = 25;
  localparam int ST_DEVSEL_HI = 26;
  localparam int ST_STA_BIT = 27;
  localparam int ST_RTA_BIT = 28;
  localparam int ST_RMA_BIT = 29;
  localparam int ST_SSE_BIT = 30;
  localparam int ST_DPE_BIT = 31;

  // Byte lanes of the configuration dword.
  localparam int LANE_CMD_LO = 0;
  localparam int LANE_CMD_HI = 1;
  localparam int LANE_ST_HI = 3;

  // ---------------------------------------------------------------
  // Fixed field values
  // ---------------------------------------------------------------
  localparam logic WAIT_CTRL_VAL = 1'b0;
  localparam logic CAP66_VAL = 1'b0;
  localparam logic FB2B_CAP_VAL = 1'b1;
  localparam logic [1:0] DEVSEL_MEDIUM = 2'h1;
  localparam logic CMD_RESET = 1'b0;
  localparam logic FLAG_RESET = 1'b0;

  // Sticky flag indices inside the flag bank.
  localparam int NFLAG = 6;
  localparam int F_DPD = 0;
  localparam int F_STA = 1;
  localparam int F_RTA = 2;
  localparam int F_RMA = 3;
  localparam int F_SSE = 4;
  localparam int F_DPE = 5;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [3:0] be_n;
    logic [31:0] wdata;
  } bpcs_cfg_req_t;

  typedef struct packed {
    logic master_active;
    logic parity_seen;
    logic addr_perr;
    logic data_perr;
    logic tgt_abort_sig;
    logic tgt_abort_rcv;
    logic mst_abort_rcv;
    logic serr_req;
  } bpcs_event_t;

  typedef struct packed {
    logic fb2b_en;
    logic serr_en;
    logic perr_resp;
  } bpcs_cmd_t;

endpackage

//--- bpcs_w1c_bank.sv
`timescale 1ns/1ps
module bpcs_w1c_bank
  import bpcs_pkg::*;
#(
  parameter int N = NFLAG
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic nrst,
  // Hardware set and software clear vectors.
  input wire logic [N-1:0] set,
  input wire logic [N-1:0] clr,
  // Registered flags.
  output logic [N-1:0] flags_r
);

  // The whole state of the bank.
  typedef struct packed {
    logic [N-1:0] flags;
  } bpcs_bank_t;

  bpcs_bank_t s_r; // Registered state.
  bpcs_bank_t s_nxt; // Next state.

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  // The set term is applied last so an event is never lost.
  always_comb begin
    s_nxt = s_r;
    s_nxt.flags = (s_r.flags & ~clr) | set;
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!nrst) begin
      s_r.flags <= {N{FLAG_RESET}};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign flags_r = s_r.flags;

endmodule

//--- bpcs_host.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Configuration master on the primary bus
// ---------------------------------------------------------------
module bpcs_host
  import bpcs_pkg::*;
(
  // Clock.
  input wire logic clock,
  // Request towards the register block.
  output bpcs_cfg_req_t req,
  // Answer from the register block.
  input wire logic [31:0] rdata,
  input wire logic ack
);
  // Idle bus at time zero.
  initial begin
    req = '0;
  end

  // One access: a one-cycle strobe, then a bounded wait for the answer.
  // Released lines show the inverse, so stale values never pass for live ones.
  // write-one clears
  task automatic access(input logic r, input logic w, input logic [7:0] a,
                        input logic [3:0] be, input logic [31:0] d,
                        output logic [31:0] q, output bit ok);
    int n;
    @(posedge clock);
    #1;
    req.rd = r;
    req.wr = w;
    req.addr = a;
    req.be_n = be;
    req.wdata = d;
    @(posedge clock);
    #1;
    req.rd = 1'b0;
    req.wr = 1'b0;
    n = 0;
    while (ack !== 1'b1 && n < 4) begin
      @(posedge clock);
      #1;
      n++;
    end
    ok = (ack === 1'b1);
    q = rdata;
    req.addr = ~a;
    req.be_n = ~be;
    req.wdata = ~d;
  endtask
endmodule

//--- tb_bpcs_regs.sv
`timescale 1ns/1ps
module tb_bpcs_regs
  import bpcs_pkg::*;
;
  // ---------------------------------------------------------------
  // Signals and model state
  // ---------------------------------------------------------------
  localparam logic [7:0] REV = 8'h01;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  bpcs_cfg_req_t cfg_req;
  logic [31:0] cfg_rdata_r;
  logic cfg_ack_r;
  bpcs_event_t events = '0;
  logic serr_o_r;
  logic serr_oe_r;
  bpcs_cmd_t cmd_r;
  logic [NFLAG-1:0] flags_r;
  // Expected command bits and sticky flags.
  bpcs_cmd_t m_cmd = '0;
  logic [5:0] m_flags = '0;
  int err_total = 0;
  int n_tests = 0;
  logic [31:0] q;
  logic [31:0] w;
  logic [3:0] be;
  int bpos[5] = '{3, 2, 1, 5, 4};
  int fidx[5] = '{1, 2, 3, 5, 5};

  // 25 ns clock.
  always #12.5 clock = ~clock;

  bpcs_regs #(.REV_NUMBER(REV), .CAP_LIST(1'b1)) u_bpcs_regs (
    .clock(clock), .nrst(nrst), .cfg_req(cfg_req), .cfg_rdata_r(cfg_rdata_r),
    .cfg_ack_r(cfg_ack_r), .events(events), .serr_o_r(serr_o_r),
    .serr_oe_r(serr_oe_r), .cmd_r(cmd_r), .flags_r(flags_r));

  bpcs_host u_bpcs_host (.clock(clock), .req(cfg_req), .rdata(cfg_rdata_r),
    .ack(cfg_ack_r));

  // ---------------------------------------------------------------
  // Expectations, compares and bus helpers
  // ---------------------------------------------------------------
  // Dword 04h as the rules lay it out.
  function automatic logic [31:0] exp_dw(bpcs_cmd_t c, logic [5:0] f);
    logic [31:0] d;
    d = '0;
    d[6] = c.perr_resp;
    d[8] = c.serr_en;
    d[9] = c.fb2b_en;
    d[20] = 1'b1;
    d[23] = 1'b1;
    d[26:25] = 2'h1;
    d[24] = f[0];
    d[31:27] = f[5:1];
    return d;
  endfunction

  task automatic cmp_dw(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: dword %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: bit %b, expected %b", $time, got, exp);
    end
  endtask

  task automatic close_out();
    $display("checks %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic bus(input logic r, input logic [7:0] a, input logic [3:0] b,
                     input logic [31:0] d);
    bit ok;
    u_bpcs_host.access(r, ~r, a, b, d, q, ok);
    if (!ok) begin
      err_total++;
      $display("wrong value at %0t: no answer", $time);
      close_out();
    end
  endtask

  task automatic check_dw();
    bus(1'b1, OFS_COMMAND, 4'hF, 32'h0);
    cmp_dw(q, exp_dw(m_cmd, m_flags));
  endtask

  // Write one to the status bit of flag f only.
  task automatic clr_flag(input int f);
    bus(1'b0, OFS_COMMAND, 4'h7, 32'h1 << ((f == 0) ? 24 : 26 + f));
    m_flags[f] = 1'b0;
  endtask

  task automatic pulse(input bpcs_event_t e);
    @(posedge clock);
    #1 events = e;
    @(posedge clock);
    #1 events = '0;
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(32'h04a51745));
    repeat (10) @(posedge clock);
    #1 nrst = 1'b1;
    // Fixed fields, reserved zeros and reset values.
    check_dw();
    bus(1'b1, OFS_REVISION, 4'hF, 32'h0);
    cmp_dw(q, {24'h0, REV});
    bus(1'b0, OFS_REVISION, 4'h0, 32'hFFFFFFFF);
    bus(1'b0, 8'h0C, 4'h0, 32'hFFFFFFFF);
    bus(1'b1, OFS_REVISION, 4'hF, 32'h0);
    cmp_dw(q, {24'h0, REV});
    bus(1'b1, 8'h0C, 4'hF, 32'h0);
    cmp_dw(q, 32'h0);
    $display("test fixed fields done");
    // Command writes, all ones first, then random data and lanes.
    for (int i = 0; i < 24; i++) begin
      w = (i == 0) ? 32'hFFFFFFFF : $urandom;
      be = (i == 0) ? 4'h0 : 4'($urandom);
      bus(1'b0, OFS_COMMAND, be, w);
      if (!be[0]) m_cmd.perr_resp = w[6];
      if (!be[1]) m_cmd.serr_en = w[8];
      if (!be[1]) m_cmd.fb2b_en = w[9];
      check_dw();
      cmp_dw({29'h0, cmd_r}, {29'h0, m_cmd});
    end
    $display("test command bits done");
    // Each abort and parity event, a zero write, then a clearing write.
    for (int k = 0; k < 5; k++) begin
      pulse(bpcs_event_t'(8'h01 << bpos[k]));
      m_flags[fidx[k]] = 1'b1;
      check_dw();
      bus(1'b0, OFS_COMMAND, 4'h7, 32'h0);
      check_dw();
      clr_flag(fidx[k]);
      check_dw();
    end
    $display("test event flags done");
    // Data parity detected needs all three conditions at once.
    for (int i = 0; i < 12; i++) begin
      w = $urandom;
      bus(1'b0, OFS_COMMAND, 4'hE, w);
      m_cmd.perr_resp = w[6];
      pulse(bpcs_event_t'({w[1:0], 6'h0}));
      bus(1'b1, OFS_COMMAND, 4'hF, 32'h0);
      cmp_bit(q[24], w[6] & w[1] & w[0]);
      cmp_bit(q[6], w[6]);
      bus(1'b0, OFS_COMMAND, 4'h7, 32'hFF000000);
      m_flags = '0;
    end
    $display("test parity detected done");
    // System error pin is gated by its enable and leaves a flag behind.
    for (int en = 0; en < 2; en++) begin
      bus(1'b0, OFS_COMMAND, 4'hD, 32'(en) << 8);
      m_cmd.serr_en = en[0];
      m_cmd.fb2b_en = 1'b0;
      pulse(bpcs_event_t'(8'h01));
      cmp_bit(serr_oe_r, en[0]);
      cmp_bit(serr_o_r, 1'b0);
      @(posedge clock);
      #1 cmp_bit(serr_oe_r, 1'b0);
      m_flags[4] = en[0];
      check_dw();
    end
    $display("test system error done");
    // A set and a clear in the same cycle leave the flag set.
    pulse(bpcs_event_t'(8'h08));
    m_flags[1] = 1'b1;
    fork
      bus(1'b0, OFS_COMMAND, 4'h7, 32'hFF000000);
      pulse(bpcs_event_t'(8'h0E));
    join
    m_flags[3:1] = 3'b111;
    m_flags[4] = 1'b0;
    check_dw();
    $display("test set over clear done");
    // Reset in mid-run returns everything to its reset value.
    @(posedge clock);
    #1 nrst = 1'b0;
    repeat (2) @(posedge clock);
    #1 nrst = 1'b1;
    cmp_dw({22'h0, serr_oe_r, cmd_r, flags_r}, 32'h0);
    m_cmd = '0;
    m_flags = '0;
    check_dw();
    $display("test second reset done");
    close_out();
  end
endmodule
